// ===== cpu_int_checker.sv
// Port-level assertions for the interrupt detect/dispatch block.
// Assumes binding into the top module; sees only its ports.
`timescale 1ns/1ps

module cpu_int_checker #(
    parameter bit FLOAT_VARIANT = 1'b0
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic reset_line_n,
    input wire logic nmi_line,
    input wire logic [15:4] interrupt_line,
    input wire logic cpu_cycle_adv,
    input wire logic branch_in_window,
    input wire logic ret_maskable,
    input wire logic ret_nonmaskable,
    input cpu_int_pkg::word_t first_annul_addr,
    input cpu_int_pkg::ctl_req_t ctl_req,
    input cpu_int_pkg::word_t ctl_rdata,
    input cpu_int_pkg::disp_cmd_t disp_cmd,
    input wire logic acknowledge_strobe,
    input cpu_int_pkg::line_num_t interrupt_number_outputs
);
    import cpu_int_pkg::*;

    // ****************************************
    // Clocking
    // ****************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // ****************************************
    // Dispatch outputs
    // ****************************************
    ack_one_shot_a: assert property (acknowledge_strobe |=> !acknowledge_strobe)
        else $error("acknowledge longer than one cycle");
    num_idle_zero_a: assert property (!acknowledge_strobe |-> interrupt_number_outputs == NUM_ZERO)
        else $error("interrupt number without acknowledge");
    ack_branch_a: assert property (!FLOAT_VARIANT && acknowledge_strobe |-> disp_cmd.force_branch)
        else $error("no forced branch with acknowledge");
    ack_branch_fp_a: assert property (FLOAT_VARIANT && acknowledge_strobe |-> ##2 disp_cmd.force_branch)
        else $error("no forced branch two cycles after acknowledge");
    target_num_a: assert property (!FLOAT_VARIANT && disp_cmd.force_branch
        |-> disp_cmd.branch_target[9:0] == {1'b0, interrupt_number_outputs, 5'h00})
        else $error("vector target does not match number");
    ack_annul_a: assert property (acknowledge_strobe |-> disp_cmd.annul && $past(disp_cmd.annul))
        else $error("acknowledge without annul");
    annul_span_a: assert property ($rose(disp_cmd.annul) && !disp_cmd.flush_pipeline
        && !FLOAT_VARIANT |-> disp_cmd.annul [*7])
        else $error("annul window too short");
    flush_annul_a: assert property (disp_cmd.flush_pipeline |-> disp_cmd.annul && !acknowledge_strobe)
        else $error("flush without annul or with acknowledge");

    // ****************************************
    // Register port
    // ****************************************
    wo_read_zero_a: assert property (ctl_req.sel inside {SEL_FLAG_SET, SEL_FLAG_CLEAR}
        |=> ctl_rdata == WORD_ZERO)
        else $error("write-only register reads nonzero");
    mask_bit0_a: assert property (ctl_req.sel == SEL_ENABLE_MASK |=> ctl_rdata[0])
        else $error("reset enable bit reads zero");

    // Main scenarios seen
    cover property (acknowledge_strobe && interrupt_number_outputs == NUM_NMI);
    cover property (acknowledge_strobe && interrupt_number_outputs == NUM_ZERO);
    cover property (disp_cmd.force_branch);

endmodule // cpu_int_checker

bind cpu_interrupt_detect_dispatch cpu_int_checker #(
    .FLOAT_VARIANT(FLOAT_VARIANT)
) cpu_int_checker_i (
    .core_clk(core_clk), .rst(rst), .reset_line_n(reset_line_n), .nmi_line(nmi_line),
    .interrupt_line(interrupt_line), .cpu_cycle_adv(cpu_cycle_adv),
    .branch_in_window(branch_in_window), .ret_maskable(ret_maskable),
    .ret_nonmaskable(ret_nonmaskable), .first_annul_addr(first_annul_addr),
    .ctl_req(ctl_req), .ctl_rdata(ctl_rdata), .disp_cmd(disp_cmd),
    .acknowledge_strobe(acknowledge_strobe),
    .interrupt_number_outputs(interrupt_number_outputs)
);

// ===== cpu_int_pkg.sv
// Constants, types and carriers for the interrupt detect/dispatch block.
// Assumes one core clock; control registers reached by a register-select port.
package cpu_int_pkg;

    // ****************************************
    // Widths and line numbering
    // ****************************************
    localparam int NUM_LINES = 16;
    localparam int WORD_W = 32;
    localparam int NUM_W = 4;
    localparam int VTP_BASE_W = 22;
    localparam int RESET_LINE = 0;
    localparam int NMI_LINE = 1;
    localparam int FIRST_MASKABLE = 4;

    typedef logic [WORD_W-1:0] word_t;
    typedef logic [NUM_LINES-1:0] line_vec_t;
    typedef logic [NUM_W-1:0] line_num_t;
    typedef logic [VTP_BASE_W-1:0] vtp_base_t;
    typedef logic [3:0] seq_t;

    // ****************************************
    // Field layouts and reset values
    // ****************************************
    localparam line_vec_t SW_FLAG_MASK = 16'hFFF0;
    localparam line_vec_t EMR_RESET_VAL = 16'h0001;
    localparam line_vec_t LINE_ZERO = 16'h0000;
    localparam word_t WORD_ZERO = 32'h0000_0000;
    localparam vtp_base_t VTP_BASE_ZERO = 22'h00_0000;
    localparam int GIE_BIT = 0;
    localparam int SAVED_GLOBAL_ENABLE_BIT = 1;
    localparam int NONMASKABLE_ENABLE_BIT = 1;
    localparam int VTP_BASE_LSB = 10;
    localparam line_num_t NUM_ZERO = 4'h0;
    localparam line_num_t NUM_NMI = 4'h1;

    // ****************************************
    // Dispatch sequence steps (step k = decision cycle + k)
    // ****************************************
    localparam seq_t SEQ_IDLE = 4'h0;
    localparam seq_t SEQ_SAVE = 4'h1;
    localparam seq_t SEQ_ANNUL = 4'h2;
    localparam seq_t SEQ_ACK = 4'h3;
    localparam seq_t SEQ_CLEAR = 4'h3;
    localparam seq_t SEQ_BR_FIXED = 4'h3;
    localparam seq_t SEQ_BR_FLOAT = 4'h5;
    localparam seq_t SEQ_END_FIXED = 4'h8;
    localparam seq_t SEQ_END_FLOAT = 4'hA;
    localparam seq_t SEQ_ONE = 4'h1;

    // ****************************************
    // Register select codes and machine states
    // ****************************************
    typedef enum logic [2:0] {
        SEL_PENDING = 3'h0,
        SEL_FLAG_SET = 3'h1,
        SEL_FLAG_CLEAR = 3'h2,
        SEL_ENABLE_MASK = 3'h3,
        SEL_MRP = 3'h4,
        SEL_NRP = 3'h5,
        SEL_VTP = 3'h6,
        SEL_STATUS = 3'h7
    } reg_sel_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_HOLD = 2'b11
    } disp_state_t;

    // Control register access from the execute unit
    typedef struct packed {
        logic wr;
        reg_sel_t sel;
        word_t wdata;
    } ctl_req_t;

    // Pipeline-side dispatch commands
    typedef struct packed {
        logic annul;
        logic force_branch;
        word_t branch_target;
        logic flush_pipeline;
    } disp_cmd_t;

endpackage

// ===== cpu_interrupt_detect_dispatch.sv
// Interrupt edge detection, pending flags, enables and dispatch sequencer.
// Assumes pins arrive asynchronously; pipeline controls are on core_clk.
//
// Contract
// - Maskable take saves 32-bit skipped packet address
// - Software writes return pointer; interrupts may overwrite
// - Maskable return restores global enable from saved
// - Rising line edge sets flag, every clock
// - Pin edge cycle 1, flag set cycle 6
// - Hardware set beats coincident clear write
// - Non-chosen flags stay until cleared or served
// - Evaluate flag, priority, enables every clock
// - No nonreset take during branch window
// - Non-NMI take: save then clear global enable
// - NMI take clears nonmaskable enable
// - Annul packets from n+5 onward
// - First annulled address to matching pointer
// - Forced vector branch cycle 7 or 9
// - Cycle 7 acknowledge with interrupt number
// - Served flag cleared in cycle 8
// - Processing spans cycles 6-12 or 6-14
// - Enables block nonreset and maskable lines
// - Flag sets on next CPU cycle boundary
// - Reset vector processing four clocks after release
// - Reset release edge sets reset flag
// - Set/clear registers act on ones only
// - Reset enable bit reads one always
// - Reset line fall flushes and clears enables
`timescale 1ns/1ps

module cpu_interrupt_detect_dispatch #(
    parameter bit FLOAT_VARIANT = 1'b0
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic reset_line_n,
    input wire logic nmi_line,
    input wire logic [15:4] interrupt_line,
    input wire logic cpu_cycle_adv,
    input wire logic branch_in_window,
    input wire logic ret_maskable,
    input wire logic ret_nonmaskable,
    input cpu_int_pkg::word_t first_annul_addr,
    input cpu_int_pkg::ctl_req_t ctl_req,
    output cpu_int_pkg::word_t ctl_rdata,
    output cpu_int_pkg::disp_cmd_t disp_cmd,
    output logic acknowledge_strobe,
    output cpu_int_pkg::line_num_t interrupt_number_outputs
);
    import cpu_int_pkg::*;

    // ****************************************
    // Pin synchronisers and edge detection
    // ****************************************
    line_vec_t raw_lines; // Pins gathered by line number
    line_vec_t s1_reg, s2_reg, s3_reg; // Three-stage synchroniser
    line_vec_t lvl_reg, lvl_next; // Accepted pin level
    line_vec_t det_reg, det_next; // Edge detected, one clock late
    line_vec_t hold_reg, hold_next; // Waiting for a CPU cycle boundary
    line_vec_t rise; // Accepted rising edges this clock
    line_vec_t arrive; // Edges landing in the flags
    logic rst_fall; // Reset line just went low

    // Reserved lines tie low
    assign raw_lines = {interrupt_line, 2'b00, nmi_line, reset_line_n};

    // Level accepted once second and third stages agree
    always_comb begin
        lvl_next = (~(s2_reg ^ s3_reg) & s2_reg) | ((s2_reg ^ s3_reg) & lvl_reg);
        rise = lvl_next & ~lvl_reg;
        rst_fall = lvl_reg[RESET_LINE] & ~lvl_next[RESET_LINE];
        det_next = rise;
        // Edges wait out a stretched CPU cycle
        if (cpu_cycle_adv) begin
            arrive = hold_reg | det_reg;
            hold_next = LINE_ZERO;
        end else begin
            arrive = LINE_ZERO;
            hold_next = hold_reg | det_reg;
        end
    end

    // Sampling runs every clock, stalls or not
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s1_reg <= LINE_ZERO;
            s2_reg <= LINE_ZERO;
            s3_reg <= LINE_ZERO;
            lvl_reg <= LINE_ZERO;
            det_reg <= LINE_ZERO;
            hold_reg <= LINE_ZERO;
        end else begin
            s1_reg <= raw_lines;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            lvl_reg <= lvl_next;
            det_reg <= det_next;
            hold_reg <= hold_next;
        end
    end

    // ****************************************
    // Priority choice and take decision
    // ****************************************
    disp_state_t st_reg, st_next; // Dispatch state
    seq_t seq_reg, seq_next; // Step within processing
    line_num_t num_reg, num_next; // Line being served
    line_vec_t flags_reg, flags_next; // Pending flags
    line_vec_t emr_reg, emr_next; // Enable mask, bit 0 fixed
    logic gie_reg, gie_next; // Global enable
    logic saved_global_enable_reg, saved_global_enable_next; // Saved global enable
    logic nonmaskable_enable_reg, nonmaskable_enable_next; // Nonmaskable enable
    line_vec_t soon; // Set now or will be set
    line_vec_t gate; // Per-line permission
    line_num_t hp_num; // Highest-priority (lowest-numbered) eligible line
    logic found; // Any line eligible
    logic take; // Start processing this clock
    logic ctl_wr_any; // Register write strobe
    logic gie_eff; // Global enable after a coincident write
    seq_t seq_end; // Last step of processing
    seq_t seq_br; // Branch step per variant

    assign seq_end = FLOAT_VARIANT ? SEQ_END_FLOAT : SEQ_END_FIXED;
    assign seq_br = FLOAT_VARIANT ? SEQ_BR_FLOAT : SEQ_BR_FIXED;
    assign ctl_wr_any = ctl_req.wr;

    // Gate, pick lowest line number, decide
    always_comb begin
        soon = flags_reg | hold_reg | det_reg | rise;
        gate = LINE_ZERO;
        gate[RESET_LINE] = 1'b1;
        gate[NMI_LINE] = nonmaskable_enable_reg;
        for (int i = FIRST_MASKABLE; i < NUM_LINES; i++) begin
            gate[i] = emr_reg[i] & gie_reg & nonmaskable_enable_reg;
        end
        found = 1'b0;
        hp_num = NUM_ZERO;
        // Downward scan leaves the lowest number
        for (int i = NUM_LINES - 1; i >= 0; i--) begin
            if (soon[i] & gate[i]) begin
                found = 1'b1;
                hp_num = line_num_t'(i);
            end
        end
        // Reset ignores branches; others wait them out
        take = (st_reg == ST_IDLE) & found
            & ((hp_num == NUM_ZERO) | ~branch_in_window);
    end

    // ****************************************
    // Flags, enables and return pointers
    // ****************************************
    word_t mrp_reg, mrp_next; // Maskable return pointer
    word_t nrp_reg, nrp_next; // Nonmaskable return pointer
    vtp_base_t vtp_reg, vtp_next; // Vector table base
    line_vec_t sw_set, sw_clr, hw_clr; // Flag write terms

    always_comb begin
        sw_set = LINE_ZERO;
        sw_clr = LINE_ZERO;
        hw_clr = LINE_ZERO;
        emr_next = emr_reg;
        nonmaskable_enable_next = nonmaskable_enable_reg;
        gie_eff = gie_reg;
        saved_global_enable_next = saved_global_enable_reg;
        mrp_next = mrp_reg;
        nrp_next = nrp_reg;
        vtp_next = vtp_reg;
        // Software writes; zeros do nothing to flags or the nonmaskable enable
        if (ctl_wr_any) begin
            unique case (ctl_req.sel)
                SEL_FLAG_SET: sw_set = ctl_req.wdata[15:0] & SW_FLAG_MASK;
                SEL_FLAG_CLEAR: sw_clr = ctl_req.wdata[15:0] & SW_FLAG_MASK;
                SEL_ENABLE_MASK: begin
                    emr_next = (ctl_req.wdata[15:0] & SW_FLAG_MASK) | EMR_RESET_VAL;
                    nonmaskable_enable_next = nonmaskable_enable_reg | ctl_req.wdata[NONMASKABLE_ENABLE_BIT];
                end
                SEL_MRP: mrp_next = ctl_req.wdata;
                SEL_NRP: nrp_next = ctl_req.wdata;
                SEL_VTP: vtp_next = ctl_req.wdata[WORD_W-1:VTP_BASE_LSB];
                SEL_STATUS: begin
                    gie_eff = ctl_req.wdata[GIE_BIT];
                    saved_global_enable_next = ctl_req.wdata[SAVED_GLOBAL_ENABLE_BIT];
                end
                SEL_PENDING: begin
                end
            endcase
        end
        gie_next = gie_eff;
        // Return branches restore enables
        if (ret_maskable) begin
            gie_next = saved_global_enable_reg;
        end
        if (ret_nonmaskable) begin
            nonmaskable_enable_next = 1'b1;
        end
        // First step of processing saves state
        if (st_reg == ST_BUSY && seq_reg == SEQ_SAVE) begin
            if (num_reg == NUM_NMI) begin
                nonmaskable_enable_next = 1'b0;
                nrp_next = first_annul_addr;
            end else begin
                saved_global_enable_next = gie_eff;
                gie_next = 1'b0;
                mrp_next = first_annul_addr;
            end
        end
        // Served flag drops as step CLEAR ends
        if (st_reg == ST_BUSY && seq_reg == SEQ_CLEAR) begin
            hw_clr[num_reg] = 1'b1;
        end
        // Arrivals win over any clear
        flags_next = (flags_reg & ~sw_clr & ~hw_clr) | sw_set | arrive;
        // Reset line fall restores reset values, except the return pointers
        if (rst_fall) begin
            flags_next = arrive;
            emr_next = EMR_RESET_VAL;
            gie_next = 1'b0;
            saved_global_enable_next = 1'b0;
            nonmaskable_enable_next = 1'b0;
            vtp_next = VTP_BASE_ZERO;
        end
    end

    // Control register storage
    always_ff @(posedge core_clk) begin
        if (rst) begin
            flags_reg <= LINE_ZERO;
            emr_reg <= EMR_RESET_VAL;
            gie_reg <= 1'b0;
            saved_global_enable_reg <= 1'b0;
            nonmaskable_enable_reg <= 1'b0;
            mrp_reg <= WORD_ZERO;
            nrp_reg <= WORD_ZERO;
            vtp_reg <= VTP_BASE_ZERO;
        end else begin
            flags_reg <= flags_next;
            emr_reg <= emr_next;
            gie_reg <= gie_next;
            saved_global_enable_reg <= saved_global_enable_next;
            nonmaskable_enable_reg <= nonmaskable_enable_next;
            mrp_reg <= mrp_next;
            nrp_reg <= nrp_next;
            vtp_reg <= vtp_next;
        end
    end

    // ****************************************
    // Dispatch sequencer
    // ****************************************
    always_comb begin
        st_next = st_reg;
        seq_next = seq_reg;
        num_next = num_reg;
        unique case (st_reg)
            // Wait for an eligible line
            ST_IDLE: begin
                if (take) begin
                    st_next = ST_BUSY;
                    seq_next = SEQ_ONE;
                    num_next = hp_num;
                end
            end
            // Step through processing, nothing else taken
            ST_BUSY: begin
                if (seq_reg == seq_end) begin
                    st_next = ST_IDLE;
                    seq_next = SEQ_IDLE;
                end else begin
                    seq_next = seq_reg + SEQ_ONE;
                end
            end
            // Reset line low: held flushed
            ST_HOLD: begin
                st_next = ST_IDLE;
                seq_next = SEQ_IDLE;
            end
            default: begin
                st_next = ST_IDLE;
                seq_next = SEQ_IDLE;
            end
        endcase
        // Low reset line aborts everything
        if (~lvl_next[RESET_LINE]) begin
            st_next = ST_HOLD;
            seq_next = SEQ_IDLE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_reg <= ST_HOLD;
            seq_reg <= SEQ_IDLE;
            num_reg <= NUM_ZERO;
        end else begin
            st_reg <= st_next;
            seq_reg <= seq_next;
            num_reg <= num_next;
        end
    end

    // ****************************************
    // Registered outputs
    // ****************************************
    disp_cmd_t cmd_reg, cmd_next; // Pipeline commands
    logic ack_reg, ack_next; // Acknowledge strobe
    line_num_t inum_reg, inum_next; // Number shown with acknowledge
    word_t rdata_reg, rdata_next; // Register read data

    always_comb begin
        cmd_next.flush_pipeline = ~lvl_next[RESET_LINE];
        // Annul from n+5 until processing ends
        cmd_next.annul = cmd_next.flush_pipeline
            | (st_next == ST_BUSY && seq_next >= SEQ_ANNUL);
        cmd_next.force_branch = (st_next == ST_BUSY) && (seq_next == seq_br);
        cmd_next.branch_target = {vtp_reg, 1'b0, num_next, 5'h00};
        ack_next = (st_next == ST_BUSY) && (seq_next == SEQ_ACK);
        inum_next = ack_next ? num_next : NUM_ZERO;
        // Read data follows the select, one clock later
        unique case (ctl_req.sel)
            SEL_PENDING: rdata_next = {16'h0000, flags_reg};
            SEL_ENABLE_MASK: rdata_next = {16'h0000, emr_reg[15:2], nonmaskable_enable_reg, 1'b1};
            SEL_MRP: rdata_next = mrp_reg;
            SEL_NRP: rdata_next = nrp_reg;
            SEL_VTP: rdata_next = {vtp_reg, 1'b0, hp_num, 5'h00};
            SEL_STATUS: rdata_next = {30'h000_0000, saved_global_enable_reg, gie_reg};
            SEL_FLAG_SET: rdata_next = WORD_ZERO;
            SEL_FLAG_CLEAR: rdata_next = WORD_ZERO;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmd_reg <= '{annul: 1'b1, force_branch: 1'b0,
                branch_target: WORD_ZERO, flush_pipeline: 1'b1};
            ack_reg <= 1'b0;
            inum_reg <= NUM_ZERO;
            rdata_reg <= WORD_ZERO;
        end else begin
            cmd_reg <= cmd_next;
            ack_reg <= ack_next;
            inum_reg <= inum_next;
            rdata_reg <= rdata_next;
        end
    end

    assign disp_cmd = cmd_reg;
    assign acknowledge_strobe = ack_reg;
    assign interrupt_number_outputs = inum_reg;
    assign ctl_rdata = rdata_reg;

endmodule // cpu_interrupt_detect_dispatch

// ===== cpu_pipe_model.sv
// Pipeline-side partner: cycle boundaries, branch window, packet address.
// Assumes the bench requests stalls and branches on core_clk.
`timescale 1ns/1ps

module cpu_pipe_model (
    input wire logic core_clk,
    input wire logic rst,
    input cpu_int_pkg::disp_cmd_t disp_cmd,
    input wire logic stall,
    input wire logic branch_busy,
    output logic cpu_cycle_adv,
    output logic branch_in_window,
    output cpu_int_pkg::word_t first_annul_addr
);
    import cpu_int_pkg::*;

    word_t pc_reg; // Address of the next packet
    word_t pc_next;

    // Stall hides the cycle boundary; branch opens the window
    assign cpu_cycle_adv = !stall;
    assign branch_in_window = branch_busy;
    assign first_annul_addr = pc_reg;

    // Jump to the vector on a forced branch
    always_comb begin
        pc_next = pc_reg;
        if (disp_cmd.force_branch) begin
            pc_next = disp_cmd.branch_target;
        end
    end

    // Address register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pc_reg <= WORD_ZERO;
        end else begin
            pc_reg <= pc_next;
        end
    end

endmodule // cpu_pipe_model

// ===== tb.sv
// Self-checking bench for the interrupt detect/dispatch block.
// Assumes the fixed-point variant and a 50 ns core clock.
`timescale 1ns/1ps

module tb;
    import cpu_int_pkg::*;

    logic core_clk, rst, reset_line_n, nmi_line, ret_maskable, ret_nonmaskable;
    logic [15:4] interrupt_line; // Maskable pins
    logic cpu_cycle_adv, branch_in_window, stall, branch_busy;
    word_t first_annul_addr, ctl_rdata;
    ctl_req_t ctl_req;
    disp_cmd_t disp_cmd;
    logic acknowledge_strobe;
    line_num_t interrupt_number_outputs;
    int bad_count = 0;
    int tests_run = 0;

    cpu_interrupt_detect_dispatch #(.FLOAT_VARIANT(1'b0)) cpu_interrupt_detect_dispatch_i (
        .core_clk(core_clk), .rst(rst), .reset_line_n(reset_line_n), .nmi_line(nmi_line),
        .interrupt_line(interrupt_line), .cpu_cycle_adv(cpu_cycle_adv),
        .branch_in_window(branch_in_window), .ret_maskable(ret_maskable),
        .ret_nonmaskable(ret_nonmaskable), .first_annul_addr(first_annul_addr),
        .ctl_req(ctl_req), .ctl_rdata(ctl_rdata), .disp_cmd(disp_cmd),
        .acknowledge_strobe(acknowledge_strobe),
        .interrupt_number_outputs(interrupt_number_outputs));

    cpu_pipe_model cpu_pipe_model_i (
        .core_clk(core_clk), .rst(rst), .disp_cmd(disp_cmd), .stall(stall),
        .branch_busy(branch_busy), .cpu_cycle_adv(cpu_cycle_adv),
        .branch_in_window(branch_in_window), .first_annul_addr(first_annul_addr));

    // ****************************************
    // Tasks
    // ****************************************
    // Word compare
    task automatic chk(input word_t a, input word_t e);
        tests_run++;
        if (a !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, a, e);
        end
    endtask

    // Register write, one strobe
    task automatic wr(input reg_sel_t s, input word_t d);
        @(posedge core_clk);
        ctl_req <= '{wr: 1'b1, sel: s, wdata: d};
        @(posedge core_clk);
        ctl_req.wr <= 1'b0;
    endtask

    // Register read, data one edge after select
    task automatic rd(input reg_sel_t s, input word_t e);
        @(posedge core_clk);
        ctl_req.sel <= s;
        @(posedge core_clk);
        #1;
        chk(ctl_rdata, e);
    endtask

    // Raise pins
    task automatic raise(input logic [15:4] v, input logic nm);
        @(posedge core_clk);
        interrupt_line <= v;
        nmi_line <= nm;
    endtask

    // Return pulse
    task automatic ret(input logic nm);
        @(posedge core_clk);
        ret_maskable <= !nm;
        ret_nonmaskable <= nm;
        @(posedge core_clk);
        ret_maskable <= 1'b0;
        ret_nonmaskable <= 1'b0;
    endtask

    // Wait for acknowledge, check number, target, latency
    task automatic wait_ack(input line_num_t num, input int lat, input word_t tgt);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (acknowledge_strobe !== 1'b1 && n < 80);
        chk(word_t'(acknowledge_strobe), 32'h0000_0001);
        chk(word_t'(interrupt_number_outputs), word_t'(num));
        chk(disp_cmd.branch_target, tgt);
        if (lat > 0) chk(word_t'(n), word_t'(lat));
        @(posedge core_clk);
        interrupt_line <= 12'h000;
        nmi_line <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask

    // Quiet window
    task automatic no_ack;
        int hits;
        hits = 0;
        repeat (20) begin
            @(posedge core_clk);
            #1;
            if (acknowledge_strobe !== 1'b0) hits++;
        end
        chk(word_t'(hits), WORD_ZERO);
    endtask

    // Verdict
    task automatic summarize;
        $display("errors %0d of %0d checks", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ****************************************
    // Clock and watchdog
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    initial begin
        repeat (3000) @(posedge core_clk);
        bad_count++;
        summarize();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        reset_line_n = 1'b0;
        nmi_line = 1'b0;
        interrupt_line = 12'h000;
        ret_maskable = 1'b0;
        ret_nonmaskable = 1'b0;
        stall = 1'b0;
        branch_busy = 1'b0;
        ctl_req = '{wr: 1'b0, sel: SEL_PENDING, wdata: WORD_ZERO};
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        repeat (12) @(posedge core_clk);
        chk(word_t'(disp_cmd.flush_pipeline), 32'h0000_0001);
        reset_line_n <= 1'b1;
        wait_ack(4'h0, 0, WORD_ZERO);
        rd(SEL_ENABLE_MASK, 32'h0000_0001);
        rd(SEL_STATUS, WORD_ZERO);
        wr(SEL_ENABLE_MASK, WORD_ZERO);
        rd(SEL_ENABLE_MASK, 32'h0000_0001);
        wr(SEL_FLAG_SET, 32'h0000_004F);
        rd(SEL_PENDING, 32'h0000_0040);
        wr(SEL_FLAG_CLEAR, WORD_ZERO);
        rd(SEL_PENDING, 32'h0000_0040);
        wr(SEL_FLAG_CLEAR, 32'h0000_0040);
        rd(SEL_PENDING, WORD_ZERO);
        wr(SEL_MRP, 32'h5555_AAAA);
        rd(SEL_MRP, 32'h5555_AAAA);
        wr(SEL_VTP, 32'h0000_8000);
        wr(SEL_ENABLE_MASK, 32'h0000_FFF2);
        rd(SEL_ENABLE_MASK, 32'h0000_FFF3);
        wr(SEL_STATUS, 32'h0000_0001);
        // Maskable take and return
        raise(12'h002, 1'b0);
        wait_ack(4'h5, 6, 32'h0000_80A0);
        rd(SEL_MRP, WORD_ZERO);
        rd(SEL_STATUS, 32'h0000_0002);
        rd(SEL_PENDING, WORD_ZERO);
        ret(1'b0);
        rd(SEL_STATUS, 32'h0000_0003);
        // Nonmaskable take
        raise(12'h000, 1'b1);
        wait_ack(4'h1, 6, 32'h0000_8020);
        rd(SEL_NRP, 32'h0000_80A0);
        rd(SEL_ENABLE_MASK, 32'h0000_FFF1);
        rd(SEL_STATUS, 32'h0000_0003);
        // Blocked while nonmaskable enable is low
        raise(12'h004, 1'b0);
        no_ack();
        rd(SEL_PENDING, 32'h0000_0040);
        ret(1'b1);
        wait_ack(4'h6, 0, 32'h0000_80C0);
        rd(SEL_MRP, 32'h0000_8020);
        ret(1'b0);
        // Held off by the branch window
        branch_busy <= 1'b1;
        raise(12'h008, 1'b0);
        no_ack();
        branch_busy <= 1'b0;
        wait_ack(4'h7, 0, 32'h0000_80E0);
        ret(1'b0);
        // Two lines at once
        raise(12'h011, 1'b0);
        wait_ack(4'h4, 6, 32'h0000_8080);
        rd(SEL_PENDING, 32'h0000_0100);
        ret(1'b0);
        wait_ack(4'h8, 0, 32'h0000_8100);
        ret(1'b0);
        // Short pulse during a memory stall
        stall <= 1'b1;
        raise(12'h020, 1'b0);
        repeat (2) @(posedge core_clk);
        interrupt_line <= 12'h000;
        stall <= 1'b0;
        wait_ack(4'h9, 0, 32'h0000_8120);
        // Clear write lands with the flag's arrival
        raise(12'h040, 1'b0);
        repeat (3) @(posedge core_clk);
        wr(SEL_FLAG_CLEAR, 32'h0000_0400);
        rd(SEL_PENDING, 32'h0000_0400);
        // Reset pin pulse in mid-run
        reset_line_n <= 1'b0;
        repeat (12) @(posedge core_clk);
        chk(word_t'(disp_cmd.flush_pipeline), 32'h0000_0001);
        reset_line_n <= 1'b1;
        wait_ack(4'h0, 0, WORD_ZERO);
        rd(SEL_PENDING, WORD_ZERO);
        rd(SEL_ENABLE_MASK, 32'h0000_0001);
        summarize();
    end

endmodule // tb
